// ---- src/utx_top.sv ----
/*
 * Serial transmitter control: queued idle, graceful disable, pin buffer
 * and port read-back, behind a classic Wishbone slave.
 * Assumes one clock, synchronous active-high reset, pin inputs synchronous.
 */
// The implementer's own choices: register access over Wishbone and the placing of the registers.
// How it works
// - With nothing to shift, the serial line stays high.
// - Characters last 10 bit times, or 11 with nine-bit select; idle is all ones.
// - Idle characters come only from a 0-to-1 change of the switch bit.
// - Rising switch queues one idle; current character continues, pin kept.
// - Queue holds shifting character, queued idle and holding register together.
// - Each switch rise queues an idle, regardless of baud phase; rises before it is sent share one idle.
// - Clearing the switch finishes the current character; only reset stops at once.
// - Disabled while idle, the pin is released on a bit-rate tick.
// - Disabled mid-character: finish it, release pin, drop queued characters.
// - That last character sets both finished and buffer-empty flags.
// - While enabled and open drain is off, transmitter forces the pin output buffer on.
// - Buffer enable is direction bit OR ownership, held until character ends.
// - One open-drain select covers all six pins; high side disabled.
// - Pin data is serial data while owned, else the port latch.
// - Port latch takes every write, even while the transmitter owns the pin.
// - Port read gives latch if direction is 1, else the live pin.
`timescale 1ns/1ps
module utx_top
	import utx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [PORT_W-1:0] port_i,
	output logic [PORT_W-1:0] port_o,
	output logic [PORT_W-1:0] port_oe_o,
	output logic irq_o
);

	logic tick, req, wr, rd, wr_lo;

	// Software-visible state
	utx_ctrl_t ctrl, next_ctrl;
	logic [7:0] latch, next_latch;
	logic [7:0] dir, next_dir;
	logic od_sel, next_od_sel;
	logic [15:0] baud, next_baud;
	logic [1:0] irq_stat, next_irq_stat;
	logic [1:0] irq_mask, next_irq_mask;
	logic [31:0] next_dat;
	logic next_ack, next_irq;

	// Transmit engine state
	utx_state_t state, next_state;
	logic [10:0] shreg, next_shreg;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] hold, next_hold;
	logic hold_full, next_hold_full, idle_q, next_idle_q;
	logic tx_buffer_empty_flag, next_tx_buffer_empty_flag, tc, next_tc, own, next_own, sw_prev;
	logic [1:0] arm, next_arm;

	logic sw_rise, free, tx_data;
	logic [3:0] frame_len;
	utx_pins_t pins, next_pins;

	utx_baud_tick u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.div_i(baud),
		.tick_o(tick)
	);

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i;
	assign rd = req & ~wb_we_i;
	assign wr_lo = wr & wb_sel_i[0];

	assign sw_rise = ctrl.tx_switch_bit & ~sw_prev;
	// Shifter frees at the last bit boundary so characters run back to back
	assign free = tick & ((state == UTX_IDLE) || (bitcnt == 4'h1));
	assign frame_len = ctrl.nine_bit ? LEN_NINE : LEN_EIGHT;
	assign tx_data = (state == UTX_SHIFT) ? shreg[0] : 1'b1;

	// Register file and bus answer
	always_comb begin
		next_ctrl = ctrl;
		next_latch = latch;
		next_dir = dir;
		next_od_sel = od_sel;
		next_baud = baud;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_dat = 32'h0000_0000;
		next_ack = req;
		if (wr_lo) begin
			unique case (wb_adr_i)
				OFS_CTRL: next_ctrl = utx_ctrl_t'(wb_dat_i[2:0]);
				OFS_LATCH: next_latch = wb_dat_i[7:0];
				OFS_DIR: next_dir = wb_dat_i[7:0];
				OFS_ODSEL: next_od_sel = wb_dat_i[0];
				OFS_IRQ_MASK: next_irq_mask = wb_dat_i[1:0];
				OFS_BAUD: next_baud[7:0] = wb_dat_i[7:0];
				default: ;
			endcase
		end
		if (wr && wb_sel_i[1] && wb_adr_i == OFS_BAUD) begin
			next_baud[15:8] = wb_dat_i[15:8];
		end
		if (rd) begin
			unique case (wb_adr_i)
				OFS_CTRL: next_dat[2:0] = ctrl;
				OFS_STATUS: next_dat[2:0] = {own, tc, tx_buffer_empty_flag};
				OFS_DATA: next_dat[7:0] = hold;
				// Read-back mux per pin, also while the transmitter drives it
				OFS_LATCH: next_dat[PORT_W-1:0] = (latch[PORT_W-1:0] & dir[PORT_W-1:0])
					| (port_i & ~dir[PORT_W-1:0]);
				OFS_DIR: next_dat[7:0] = dir;
				OFS_ODSEL: next_dat[0] = od_sel;
				OFS_BAUD: next_dat[15:0] = baud;
				OFS_IRQ_STAT: next_dat[1:0] = irq_stat;
				OFS_IRQ_MASK: next_dat[1:0] = irq_mask;
				default: ;
			endcase
		end
		// Read clears, but a fresh event in the same cycle survives
		if (rd && wb_adr_i == OFS_IRQ_STAT) begin
			next_irq_stat = 2'b00;
		end
		next_irq_stat[ST_TX_BUFFER_EMPTY_FLAG] = next_irq_stat[ST_TX_BUFFER_EMPTY_FLAG] | (next_tx_buffer_empty_flag & ~tx_buffer_empty_flag);
		next_irq_stat[ST_TC] = next_irq_stat[ST_TC] | (next_tc & ~tc);
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RST;
			latch <= LATCH_RST;
			dir <= DIR_RST;
			od_sel <= 1'b0;
			baud <= BAUD_RST;
			irq_mask <= 2'b00;
			irq_stat <= 2'b00;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			latch <= next_latch;
			dir <= next_dir;
			od_sel <= next_od_sel;
			baud <= next_baud;
			irq_mask <= next_irq_mask;
			irq_stat <= next_irq_stat;
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
			irq_o <= next_irq;
		end
	end

	// Transmit engine
	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_hold = hold;
		next_hold_full = hold_full;
		next_idle_q = idle_q;
		next_tx_buffer_empty_flag = tx_buffer_empty_flag;
		next_tc = tc;
		next_own = own;
		next_arm = arm;
		// Status read arms the clear of whichever flags are set
		if (rd && wb_adr_i == OFS_STATUS) begin
			next_arm = {tc, tx_buffer_empty_flag};
		end
		if (wr_lo && wb_adr_i == OFS_DATA) begin
			if (arm[ST_TX_BUFFER_EMPTY_FLAG]) begin
				next_tx_buffer_empty_flag = 1'b0;
			end
			if (arm[ST_TC]) begin
				next_tc = 1'b0;
			end
			next_arm = 2'b00;
		end
		if (state == UTX_SHIFT && tick) begin
			next_shreg = {1'b1, shreg[10:1]};
			next_bitcnt = bitcnt - 4'h1;
		end
		if (free) begin
			if (!ctrl.tx_switch_bit) begin
				next_state = UTX_IDLE;
				next_own = 1'b0;
				if (state == UTX_SHIFT) begin
					next_idle_q = 1'b0;
					next_hold_full = 1'b0;
					next_tx_buffer_empty_flag = 1'b1;
					next_tc = 1'b1;
				end
			end else if (idle_q) begin
				// Idle character: all ones, no start or stop
				next_state = UTX_SHIFT;
				next_shreg = 11'h7ff;
				next_bitcnt = frame_len;
				next_idle_q = 1'b0;
			end else if (hold_full) begin
				next_state = UTX_SHIFT;
				next_shreg = ctrl.nine_bit ? {1'b1, ctrl.t8, hold, 1'b0}
					: {2'b11, hold, 1'b0};
				next_bitcnt = frame_len;
				next_hold_full = 1'b0;
				next_tx_buffer_empty_flag = 1'b1;
			end else begin
				next_state = UTX_IDLE;
				if (state == UTX_SHIFT) begin
					next_tc = 1'b1;
				end
			end
		end
		// Edge is taken on the register, not the baud tick, so never twice
		if (sw_rise) begin
			next_idle_q = 1'b1;
		end
		if (ctrl.tx_switch_bit) begin
			next_own = 1'b1;
		end
		// Writes while disabled are kept but never queued
		if (wr_lo && wb_adr_i == OFS_DATA) begin
			next_hold = wb_dat_i[7:0];
			next_hold_full = ctrl.tx_switch_bit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= UTX_IDLE;
			shreg <= 11'h7ff;
			bitcnt <= 4'h0;
			hold <= 8'h00;
			hold_full <= 1'b0;
			idle_q <= 1'b0;
			tx_buffer_empty_flag <= 1'b1;
			tc <= 1'b1;
			own <= 1'b0;
			sw_prev <= 1'b0;
			arm <= 2'b00;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			hold <= next_hold;
			hold_full <= next_hold_full;
			idle_q <= next_idle_q;
			tx_buffer_empty_flag <= next_tx_buffer_empty_flag;
			tc <= next_tc;
			own <= next_own;
			sw_prev <= ctrl.tx_switch_bit;
			arm <= next_arm;
		end
	end

	// Pin buffers
	always_comb begin
		next_pins.data = latch[PORT_W-1:0];
		next_pins.oe = dir[PORT_W-1:0];
		next_pins.data[TXD_PIN] = own ? tx_data : latch[TXD_PIN];
		next_pins.oe[TXD_PIN] = dir[TXD_PIN] | own;
		// Open drain drives low only, a pull-up makes the high
		if (od_sel) begin
			next_pins.oe = next_pins.oe & ~next_pins.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins <= '0;
		end else begin
			pins <= next_pins;
		end
	end

	assign port_o = pins.data;
	assign port_oe_o = pins.oe;

	// Helper: ticks spent in the current character
	logic [3:0] char_ticks, next_char_ticks;

	always_comb begin
		next_char_ticks = char_ticks;
		if (state == UTX_IDLE || (free && state == UTX_SHIFT)) begin
			next_char_ticks = 4'h0;
		end else if (tick) begin
			next_char_ticks = char_ticks + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			char_ticks <= 4'h0;
		end else begin
			char_ticks <= next_char_ticks;
		end
	end

	idle_line_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
		own && state == UTX_IDLE |=> port_o[TXD_PIN])
		else $error("line not high while idle");

	char_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
		free && state == UTX_SHIFT |-> char_ticks == frame_len - 4'h1)
		else $error("character length wrong");

	idle_from_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(idle_q) |-> $past(sw_rise))
		else $error("idle queued without switch rise");

	rise_queues_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sw_rise |=> idle_q || (state == UTX_SHIFT && shreg == 11'h7ff))
		else $error("switch rise lost");

	keep_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state == UTX_SHIFT |-> own)
		else $error("pin released mid character");

	disable_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		free && state == UTX_SHIFT && !ctrl.tx_switch_bit
		|=> state == UTX_IDLE && !idle_q && !own ##0 tx_buffer_empty_flag && tc)
		else $error("disable did not finish cleanly");

	release_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(own) |-> $past(tick) && !$past(ctrl.tx_switch_bit))
		else $error("pin released off tick");

	force_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
		own && !od_sel |=> port_oe_o[TXD_PIN])
		else $error("buffer not forced on");

	latch_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_lo && wb_adr_i == OFS_LATCH |=> latch == $past(wb_dat_i[7:0]))
		else $error("port latch missed a write");

	open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
		od_sel ##1 od_sel |-> (port_oe_o & port_o) == '0)
		else $error("high side driven in open drain");

	three_deep_c: cover property (@(posedge clk_i) disable iff (rst_i)
		state == UTX_SHIFT && idle_q && hold_full);

	idle_char_c: cover property (@(posedge clk_i) disable iff (rst_i)
		free && idle_q && ctrl.tx_switch_bit);

	disable_mid_c: cover property (@(posedge clk_i) disable iff (rst_i)
		free && state == UTX_SHIFT && !ctrl.tx_switch_bit);

	irq_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));

endmodule

// ---- src/utx_pkg.sv ----
/*
 * Shared constants and types for the serial transmit control block.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package utx_pkg;

	localparam int ADR_W = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_LATCH = 8'h0c;
	localparam logic [7:0] OFS_DIR = 8'h10;
	localparam logic [7:0] OFS_ODSEL = 8'h14;
	localparam logic [7:0] OFS_BAUD = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

	// Status and interrupt bit positions
	localparam int ST_TX_BUFFER_EMPTY_FLAG = 0;
	localparam int ST_TC = 1;
	localparam int ST_OWN = 2;

	localparam int TXD_PIN = 1;
	localparam int PORT_W = 6;

	// Character lengths in bit times
	localparam logic [3:0] LEN_EIGHT = 4'ha;
	localparam logic [3:0] LEN_NINE = 4'hb;

	localparam logic [15:0] BAUD_RST = 16'h000f;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] LATCH_RST = 8'h00;

	typedef struct packed {
		logic t8;
		logic nine_bit;
		logic tx_switch_bit;
	} utx_ctrl_t;

	localparam utx_ctrl_t CTRL_RST = '{t8: 1'b0, nine_bit: 1'b0, tx_switch_bit: 1'b0};

	typedef struct packed {
		logic [PORT_W-1:0] data;
		logic [PORT_W-1:0] oe;
	} utx_pins_t;

	typedef enum logic {
		UTX_IDLE,
		UTX_SHIFT
	} utx_state_t;

endpackage

// ---- src/utx_baud_tick.sv ----
/*
 * Bit-rate tick generator: one-cycle pulse every div+1 clocks.
 * Assumes a synchronous, active-high reset.
 */
`timescale 1ns/1ps
module utx_baud_tick
	import utx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] div_i,
	output logic tick_o
);

	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic next_tick;

	always_comb begin
		next_cnt = cnt - 16'h0001;
		next_tick = 1'b0;
		if (cnt == 16'h0000) begin
			next_cnt = div_i;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= BAUD_RST;
			tick_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end

endmodule

// ---- testbench/utx_rx_model.sv ----
/*
 * Far-end serial receiver model: start, 8 or 9 data bits LSB first, stop.
 * Assumes an idle-high line and a bit time of BIT clocks.
 */
`timescale 1ns/1ps
module utx_rx_model #(
	parameter int BIT = 4
) (
	input wire logic clk_i,
	input wire logic line_i,
	input wire logic nine_i,
	output logic [7:0] rx_data_o,
	output logic [7:0] rx_count_o,
	output logic rx_ninth_o,
	output logic rx_bad_o
);
	logic [10:0] frame;
	int last;
	initial begin
		rx_data_o = 8'h00;
		rx_count_o = 8'h00;
		rx_ninth_o = 1'b0;
		rx_bad_o = 1'b0;
	end
	// Samples mid-bit; stops at mid stop bit so the next start is not missed
	// Results land non-blocking so the bench never races them
	always begin
		@(posedge clk_i);
		if (line_i === 1'b0) begin
			last = nine_i ? 10 : 9;
			repeat (BIT / 2) @(posedge clk_i);
			for (int i = 0; i <= last; i++) begin
				frame[i] = line_i;
				if (i < last)
					repeat (BIT) @(posedge clk_i);
			end
			rx_data_o <= frame[8:1];
			rx_ninth_o <= nine_i & frame[9];
			rx_bad_o <= rx_bad_o | frame[0] | ~frame[last];
			rx_count_o <= rx_count_o + 8'h01;
		end
	end
endmodule

// ---- testbench/tb_top.sv ----
/*
 * Bench for the serial transmit control block.
 * Assumes the receiver model on pin 1 and pull-ups on every port pin.
 */
`timescale 1ns/1ps
module tb_top
	import utx_pkg::*;
;
	localparam int BIT = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [ADR_W-1:0] adr = '0;
	logic [31:0] wdat = '0;
	logic [31:0] rdat;
	logic [31:0] dat_o;
	logic ack;
	logic [PORT_W-1:0] pin_o;
	logic [PORT_W-1:0] pin_oe;
	logic [PORT_W-1:0] pin_i;
	logic irq;
	logic [7:0] rx_data;
	logic [7:0] rx_count;
	logic rx_bad;
	logic rx_ninth;
	logic nine = 1'b0;
	logic watch = 1'b0;
	logic oe_lost = 1'b0;
	int errors = 0;
	int num_checks = 0;
	int n;
	int mark;
	int since = 0;

	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) since <= since + 1;
	always @(posedge clk_i) if (watch && pin_oe[TXD_PIN] !== 1'b1) oe_lost <= 1'b1;
	// Released pins float up through the pull-ups
	assign pin_i = (pin_o & pin_oe) | ~pin_oe;

	utx_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.port_i(pin_i), .port_o(pin_o), .port_oe_o(pin_oe), .irq_o(irq));
	utx_rx_model #(.BIT(BIT)) far (.clk_i(clk_i), .line_i(pin_i[TXD_PIN]), .rx_data_o(rx_data),
		.rx_count_o(rx_count), .rx_bad_o(rx_bad), .nine_i(nine), .rx_ninth_o(rx_ninth));

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic hang(input string what);
		errors++;
		$display("MISMATCH %s expected done seen timeout", what);
		give_verdict();
	endtask

	task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20)
			hang("wishbone ack");
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		chk(what, exp, rdat);
	endtask

	task automatic wait_line_low();
		n = 0;
		while (pin_i[TXD_PIN] !== 1'b0 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 400)
			hang("line low");
	endtask

	task automatic wait_rx(input logic [7:0] c);
		int k;
		k = 0;
		while (rx_count !== c && k < 400) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 400)
			hang("received char");
	endtask

	// Status read with the flag set arms the clear by the next data write
	task automatic wait_tx_buffer_empty_flag();
		int k;
		k = 0;
		do begin
			wb(1'b0, OFS_STATUS, 32'h0);
			k++;
		end while (rdat[ST_TX_BUFFER_EMPTY_FLAG] !== 1'b1 && k < 100);
		if (k >= 100)
			hang("buffer empty");
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(OFS_STATUS, 32'h3, "status reset");
		rd(OFS_BAUD, 32'h000f, "baud reset");
		rd(8'hfc, 32'h0, "unmapped read");
		wb(1'b1, OFS_BAUD, 32'h3);
		wb(1'b1, OFS_CTRL, 32'h1);
		mark = since;
		wb(1'b1, OFS_DATA, 32'h55);
		chk("oe enabled", 32'h1, 32'(pin_oe[TXD_PIN]));
		wait_line_low();
		chk("preamble", 32'h1, 32'(since - mark >= 10 * BIT && since - mark <= 13 * BIT));
		wait_rx(8'h1);
		chk("first char", 32'h55, 32'(rx_data));
		repeat (BIT) @(posedge clk_i);
		rd(OFS_STATUS, 32'h7, "idle enabled status");
		wait_tx_buffer_empty_flag();
		wb(1'b1, OFS_DATA, 32'ha5);
		wait_tx_buffer_empty_flag();
		watch <= 1'b1;
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b1, OFS_CTRL, 32'h1);
		wait_tx_buffer_empty_flag();
		wb(1'b1, OFS_DATA, 32'h5a);
		wait_rx(8'h2);
		chk("last char", 32'ha5, 32'(rx_data));
		wait_line_low();
		chk("one idle gap", 32'h1, 32'(n >= 10 * BIT && n <= 13 * BIT));
		wait_rx(8'h3);
		chk("next char", 32'h5a, 32'(rx_data));
		watch <= 1'b0;
		chk("pin kept", 32'h0, 32'(oe_lost));
		wb(1'b1, OFS_LATCH, 32'h0);
		wb(1'b1, OFS_DIR, 32'h2);
		rd(OFS_LATCH, 32'h3d, "latch readback");
		chk("serial data on pin", 32'h1, 32'(pin_o[TXD_PIN]));
		wb(1'b1, OFS_LATCH, 32'h2);
		wait_tx_buffer_empty_flag();
		wb(1'b1, OFS_DATA, 32'h3c);
		wait_tx_buffer_empty_flag();
		wb(1'b1, OFS_DATA, 32'hc3);
		wb(1'b1, OFS_CTRL, 32'h0);
		wait_rx(8'h4);
		chk("finished char", 32'h3c, 32'(rx_data));
		repeat (30 * BIT) @(posedge clk_i);
		chk("queue dropped", 32'h4, 32'(rx_count));
		chk("no framing fault", 32'h0, 32'(rx_bad));
		rd(OFS_STATUS, 32'h3, "flags after disable");
		chk("driven high release", 32'h3, 32'({pin_oe[TXD_PIN], pin_o[TXD_PIN]}));
		wb(1'b1, OFS_DIR, 32'h0);
		repeat (2) @(posedge clk_i);
		chk("high impedance", 32'h0, 32'(pin_oe[TXD_PIN]));
		wb(1'b1, OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk_i);
		chk("irq masked", 32'h0, 32'(irq));
		wb(1'b1, OFS_IRQ_MASK, 32'h3);
		repeat (2) @(posedge clk_i);
		chk("irq raised", 32'h1, 32'(irq));
		rd(OFS_IRQ_STAT, 32'h3, "irq status");
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 32'h0, 32'(irq));
		wb(1'b1, OFS_CTRL, 32'h1);
		repeat (14 * BIT) @(posedge clk_i);
		wb(1'b1, OFS_CTRL, 32'h0);
		repeat (2 * BIT) @(posedge clk_i);
		rd(OFS_STATUS, 32'h3, "idle disable status");
		chk("idle disable pin", 32'h0, 32'(pin_oe[TXD_PIN]));
		nine <= 1'b1;
		wb(1'b1, OFS_CTRL, 32'h3);
		mark = since;
		wait_tx_buffer_empty_flag();
		wb(1'b1, OFS_DATA, 32'h96);
		wait_line_low();
		chk("nine-bit idle", 32'h1, 32'(since - mark > 11 * BIT + 2 && since - mark <= 13 * BIT));
		wait_rx(8'h5);
		chk("nine-bit char", 32'h096, 32'({rx_bad, rx_ninth, rx_data}));
		repeat (2 * BIT) @(posedge clk_i);
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b1, OFS_DIR, 32'h3f);
		wb(1'b1, OFS_LATCH, 32'h3f);
		wb(1'b1, OFS_ODSEL, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("open drain high", 32'h0, 32'(pin_oe));
		wb(1'b1, OFS_LATCH, 32'h0);
		repeat (2) @(posedge clk_i);
		chk("open drain low", 32'hfc0, 32'({pin_oe, pin_o}));
		give_verdict();
	end
endmodule
